// ===== isf_pkg.sv
// shared constants for the interrupt request status flag block
package isf_pkg;

	// line and source counts
	localparam int ISF_LINES = 8;
	localparam int ISF_KEYS = 8;
	localparam int ISF_WAKES = 8;
	localparam int ISF_PINS = 24;
	localparam int ISF_SRCS = 10;
	localparam int ISF_EVTS = 2;

	// first pin index of the key-in and wake-up groups in the combined pin vector
	localparam int ISF_KEY_BASE = 8;
	localparam int ISF_WAKE_BASE = 16;

	// apb byte offsets
	localparam logic [7:0] ISF_OFF_STATUS = 8'h00;
	localparam logic [7:0] ISF_OFF_SENSE = 8'h04;
	localparam logic [7:0] ISF_OFF_ENABLE = 8'h08;
	localparam logic [7:0] ISF_OFF_LEVEL = 8'h0c;
	localparam logic [7:0] ISF_OFF_CONFIG = 8'h10;
	localparam logic [7:0] ISF_OFF_EVT_STATUS = 8'h14;
	localparam logic [7:0] ISF_OFF_EVT_MASK = 8'h18;

	// reset values
	localparam logic [7:0] ISF_RST_STATUS = 8'h00;
	localparam logic [15:0] ISF_RST_SENSE = 16'h0000;
	localparam logic [7:0] ISF_RST_ENABLE = 8'h00;
	localparam logic [9:0] ISF_RST_LEVEL = 10'h000;
	localparam logic ISF_RST_DTC = 1'b0;
	localparam logic [1:0] ISF_RST_EVT = 2'h0;
	localparam logic [31:0] ISF_RST_RDATA = 32'h0000_0000;
	localparam logic ISF_PIN_IDLE = 1'b1;

	// field positions
	localparam int ISF_CFG_DTC_BIT = 0;
	localparam int ISF_EVT_KEY_BIT = 0;
	localparam int ISF_EVT_WAKE_BIT = 1;
	localparam int ISF_SENSE_W = 2;

	// detection mode per request line
	typedef enum logic [1:0] {
		ISF_SENSE_LOW = 2'b00,
		ISF_SENSE_FALL = 2'b01,
		ISF_SENSE_RISE = 2'b10,
		ISF_SENSE_BOTH = 2'b11
	} isf_sense_t;

endpackage

// ===== isf_detect.sv
`timescale 1ns/1ps
// one pin: two-stage synchroniser, history flop and condition detect
module isf_detect (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic pin,
	input wire isf_pkg::isf_sense_t sense,
	output logic level,
	output logic hit
);
	import isf_pkg::*;

	logic s1_reg;
	logic s2_reg;
	logic prev_reg;
	logic fell;
	logic rose;

	// synchroniser and history, idle high
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_reg <= ISF_PIN_IDLE;
			s2_reg <= ISF_PIN_IDLE;
			prev_reg <= ISF_PIN_IDLE;
		end else begin
			s1_reg <= pin;
			s2_reg <= s1_reg;
			prev_reg <= s2_reg;
		end
	end

	// edges seen on the synchronised level
	assign fell = prev_reg & ~s2_reg;
	assign rose = ~prev_reg & s2_reg;
	assign level = s2_reg;

	// selected detection condition
	always_comb begin
		case (sense)
			ISF_SENSE_LOW: hit = ~s2_reg;
			ISF_SENSE_FALL: hit = fell;
			ISF_SENSE_RISE: hit = rose;
			ISF_SENSE_BOTH: hit = fell | rose;
			default: hit = 1'b0;
		endcase
	end
endmodule

// ===== isf_top.sv
`timescale 1ns/1ps
module isf_top (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [isf_pkg::ISF_LINES-1:0] external_request_pin,
	input wire logic [isf_pkg::ISF_KEYS-1:0] key_in_input,
	input wire logic [isf_pkg::ISF_WAKES-1:0] wake_up_event_input,
	input wire logic [isf_pkg::ISF_LINES-1:0] exc_ack,
	output logic [isf_pkg::ISF_LINES-1:0] ext_request,
	output logic [isf_pkg::ISF_SRCS-1:0] source_level,
	output logic irq
);
	import isf_pkg::*;

	// registers
	logic [7:0] status_reg;
	logic [7:0] status_next;
	logic [15:0] sense_reg;
	logic [7:0] enable_reg;
	logic [9:0] level_reg;
	logic dtc_reg;
	logic [1:0] evt_reg;
	logic [1:0] evt_next;
	logic [1:0] evt_mask_reg;
	logic [31:0] prdata_reg;

	// per-pin detect results
	logic [ISF_PINS-1:0] pin_vec;
	logic [ISF_PINS-1:0] lvl_vec;
	logic [ISF_PINS-1:0] hit_vec;
	logic [ISF_LINES-1:0] mode_low;
	logic [ISF_LINES-1:0] auto_clr;
	logic [ISF_LINES-1:0] sw_clr;
	logic [ISF_LINES-1:0] line_hit;
	logic key_hit;
	logic wake_hit;

	// bus decode
	logic access;
	logic wr_en;
	logic rd_setup;
	logic hit_status;
	logic hit_sense;
	logic hit_enable;
	logic hit_level;
	logic hit_config;
	logic hit_evt;
	logic hit_evt_mask;
	logic addr_hit;
	logic [31:0] read_mux;

	// apb decode, zero wait states
	assign access = psel & penable;
	assign wr_en = access & pwrite;
	assign rd_setup = psel & ~penable & ~pwrite;
	assign hit_status = (paddr == ISF_OFF_STATUS);
	assign hit_sense = (paddr == ISF_OFF_SENSE);
	assign hit_enable = (paddr == ISF_OFF_ENABLE);
	assign hit_level = (paddr == ISF_OFF_LEVEL);
	assign hit_config = (paddr == ISF_OFF_CONFIG);
	assign hit_evt = (paddr == ISF_OFF_EVT_STATUS);
	assign hit_evt_mask = (paddr == ISF_OFF_EVT_MASK);
	assign addr_hit = hit_status | hit_sense | hit_enable | hit_level
		| hit_config | hit_evt | hit_evt_mask;
	assign pready = 1'b1;
	assign pslverr = access & ~addr_hit;

	// read data selection, unmapped reads zero
	assign read_mux = hit_status ? {24'h000000, status_reg} :
		hit_sense ? {16'h0000, sense_reg} :
		hit_enable ? {24'h000000, enable_reg} :
		hit_level ? {22'h0, level_reg} :
		hit_config ? {31'h0, dtc_reg} :
		hit_evt ? {30'h0, evt_reg} :
		hit_evt_mask ? {30'h0, evt_mask_reg} :
		32'h0000_0000;

	// read data captured in the setup cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_reg <= ISF_RST_RDATA;
		end else if (rd_setup) begin
			prdata_reg <= read_mux;
		end
	end
	assign prdata = prdata_reg;

	// all pins in one vector: request lines, key-in, wake-up
	assign pin_vec = {wake_up_event_input, key_in_input, external_request_pin};

	// per-pin detection and per-line automatic clear
	genvar gi;
	generate
		for (gi = 0; gi < ISF_PINS; gi++) begin : g_pin
			if (gi < ISF_LINES) begin : g_line
				isf_sense_t line_sense;
				assign line_sense = isf_sense_t'(sense_reg[gi*ISF_SENSE_W +: ISF_SENSE_W]);
				isf_detect u_det (
					.pclk(pclk),
					.presetn(presetn),
					.pin(pin_vec[gi]),
					.sense(line_sense),
					.level(lvl_vec[gi]),
					.hit(hit_vec[gi])
				);
				assign mode_low[gi] = (line_sense == ISF_SENSE_LOW);
				assign auto_clr[gi] = exc_ack[gi] & ~dtc_reg & (~mode_low[gi] | lvl_vec[gi]);
			end else begin : g_evt
				// key-in and wake-up on falling edge
				isf_detect u_det (
					.pclk(pclk),
					.presetn(presetn),
					.pin(pin_vec[gi]),
					.sense(ISF_SENSE_FALL),
					.level(lvl_vec[gi]),
					.hit(hit_vec[gi])
				);
			end
		end
	endgenerate

	assign line_hit = hit_vec[ISF_LINES-1:0];
	assign key_hit = |hit_vec[ISF_KEY_BASE +: ISF_KEYS];
	assign wake_hit = |hit_vec[ISF_WAKE_BASE +: ISF_WAKES];

	assign sw_clr = (wr_en & hit_status) ? ~pwdata[ISF_LINES-1:0] : 8'h00;

	assign status_next = (status_reg & ~(sw_clr | auto_clr)) | line_hit;

	// event flags, write one to clear, set wins
	assign evt_next = (evt_reg & ~((wr_en & hit_evt) ? pwdata[1:0] : 2'h0))
		| {wake_hit, key_hit};

	// flag registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_reg <= ISF_RST_STATUS;
			evt_reg <= ISF_RST_EVT;
		end else begin
			status_reg <= status_next;
			evt_reg <= evt_next;
		end
	end

	// configuration registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sense_reg <= ISF_RST_SENSE;
			enable_reg <= ISF_RST_ENABLE;
			level_reg <= ISF_RST_LEVEL;
			dtc_reg <= ISF_RST_DTC;
			evt_mask_reg <= ISF_RST_EVT;
		end else if (wr_en) begin
			if (hit_sense) sense_reg <= pwdata[15:0];
			if (hit_enable) enable_reg <= pwdata[7:0];
			if (hit_level) level_reg <= pwdata[ISF_SRCS-1:0];
			if (hit_config) dtc_reg <= pwdata[ISF_CFG_DTC_BIT];
			if (hit_evt_mask) evt_mask_reg <= pwdata[1:0];
		end
	end

	// requests towards the cpu exception logic
	assign ext_request = status_reg & enable_reg;
	assign source_level = level_reg;
	assign irq = (|ext_request) | (|(evt_reg & evt_mask_reg));

	// checks
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	logic [7:0] edge_clr;
	logic [7:0] low_clr;
	logic [7:0] low_hold;
	assign edge_clr = exc_ack & ~mode_low & ~line_hit & {8{~dtc_reg}} & ~sw_clr;
	assign low_clr = exc_ack & mode_low & lvl_vec[ISF_LINES-1:0] & ~line_hit & {8{~dtc_reg}};
	assign low_hold = exc_ack & mode_low & ~lvl_vec[ISF_LINES-1:0];

	a_level_write: assert property ((wr_en && hit_level) |=>
		(source_level == $past(pwdata[ISF_SRCS-1:0])))
		else $error("priority level not taken from write");

	a_low_clear: assert property ((low_clr != 8'h00) |=>
		((status_reg & $past(low_clr)) == 8'h00))
		else $error("low-level flag not cleared with pin high");

	a_low_hold: assert property ((low_hold != 8'h00) |=>
		((status_reg & $past(low_hold)) == $past(low_hold)))
		else $error("low-level flag lost while pin low");

	a_edge_clear: assert property ((edge_clr != 8'h00) |=>
		((status_reg & $past(edge_clr)) == 8'h00))
		else $error("edge flag not cleared on handling");

	a_dtc_keep: assert property ((dtc_reg && !(wr_en && hit_status)) |=>
		((status_reg & $past(status_reg)) == $past(status_reg)))
		else $error("flag cleared automatically with controller fitted");

	a_no_sw_set: assert property (
		((status_reg & ~$past(status_reg) & ~$past(line_hit)) == 8'h00))
		else $error("flag rose without a pin condition");

	a_sw_clear: assert property ((wr_en && hit_status) |=>
		((status_reg & ~$past(pwdata[7:0]) & ~$past(line_hit)) == 8'h00))
		else $error("written zero did not clear flag");

	a_key_event: assert property (key_hit |=> evt_reg[ISF_EVT_KEY_BIT])
		else $error("key-in edge did not set event");

	a_wake_event: assert property (wake_hit |=> evt_reg[ISF_EVT_WAKE_BIT])
		else $error("wake-up edge did not set event");

	a_set_flag: assert property ((line_hit != 8'h00) |=>
		((status_reg & $past(line_hit)) == $past(line_hit)))
		else $error("pin condition did not set flag");

	// stickiness, events, bus reads and the interrupt output

	a_flag_sticky: assert property (((status_reg != 8'h00) && !(wr_en && hit_status)
		&& (exc_ack == 8'h00)) |=> ((status_reg & $past(status_reg)) == $past(status_reg)))
		else $error("flag dropped without a clear");

	a_sw_one_keep: assert property ((wr_en && hit_status && (exc_ack == 8'h00)) |=>
		((status_reg & $past(status_reg & pwdata[7:0])) == $past(status_reg & pwdata[7:0])))
		else $error("written one cleared a flag");

	a_read_flags: assert property ((rd_setup && hit_status) |=>
		(prdata == {24'h000000, $past(status_reg)}))
		else $error("status read data wrong");

	a_evt_sticky: assert property (((evt_reg != 2'h0) && !(wr_en && hit_evt)) |=>
		((evt_reg & $past(evt_reg)) == $past(evt_reg)))
		else $error("event flag dropped without a clear");

	a_evt_rise: assert property (
		((evt_reg & ~$past(evt_reg) & ~$past({wake_hit, key_hit})) == 2'h0))
		else $error("event flag rose without an edge");

	a_key_clear: assert property ((wr_en && hit_evt && !key_hit
		&& pwdata[ISF_EVT_KEY_BIT]) |=> !evt_reg[ISF_EVT_KEY_BIT])
		else $error("key-in event not cleared by written one");

	a_wake_clear: assert property ((wr_en && hit_evt && !wake_hit
		&& pwdata[ISF_EVT_WAKE_BIT]) |=> !evt_reg[ISF_EVT_WAKE_BIT])
		else $error("wake-up event not cleared by written one");

	a_read_events: assert property ((rd_setup && hit_evt) |=>
		(prdata == {30'h0, $past(evt_reg)}))
		else $error("event read data wrong");

	a_level_hold: assert property (!(wr_en && hit_level) |=> $stable(source_level))
		else $error("priority level changed without a write");

	a_irq_level: assert property (
		irq == ((ext_request != 8'h00) || ((evt_reg & evt_mask_reg) != 2'h0)))
		else $error("interrupt output wrong");

	c_edge_clear: cover property (edge_clr != 8'h00);
	c_low_clear: cover property (low_clr != 8'h00);
	c_sw_clear: cover property ((wr_en && hit_status) ##1 (status_reg == 8'h00));
	c_dtc_ack: cover property (dtc_reg && (exc_ack & status_reg) != 8'h00);
	c_irq_event: cover property (irq && (evt_reg != 2'h0));
endmodule

// ===== isf_far_model.sv
`timescale 1ns/1ps
// far side: request pins, key and wake inputs, cpu exception acks
module isf_far_model (
	input wire logic pclk,
	output logic [7:0] pin,
	output logic [7:0] key,
	output logic [7:0] wake,
	output logic [7:0] ack
);
	// all inputs idle high, no handling running
	initial begin
		pin = 8'hff;
		key = 8'hff;
		wake = 8'hff;
		ack = 8'h00;
	end
	// new level on all request pins
	task automatic drive(input logic [7:0] v);
		@(posedge pclk);
		pin <= v;
	endtask
	// one-cycle handling pulse for line n
	task automatic handle(input int n);
		@(posedge pclk);
		ack <= 8'h01 << n;
		@(posedge pclk);
		ack <= 8'h00;
	endtask
	task automatic blip(input logic wk, input int n);
		@(posedge pclk);
		if (wk) wake[n] <= 1'b0;
		else key[n] <= 1'b0;
		repeat (3) @(posedge pclk);
		wake <= 8'hff;
		key <= 8'hff;
	endtask
endmodule

// ===== test_irq_status_flag_logic.sv
`timescale 1ns/1ps
module test_irq_status_flag_logic;
	import isf_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, slv;
	logic [7:0] paddr, pin, key, wake, ack, ext_request;
	logic [31:0] pwdata, prdata, rdata;
	logic [9:0] source_level;
	int errors, cmp_count;

	isf_far_model u_far (.pclk(pclk), .pin(pin), .key(key), .wake(wake), .ack(ack));
	isf_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .external_request_pin(pin), .key_in_input(key),
		.wake_up_event_input(wake), .exc_ack(ack), .ext_request(ext_request),
		.source_level(source_level), .irq(irq));

	// compare and count
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic end_of_test;
		if (errors == 0 && cmp_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// one apb transfer, idle cycle after it
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge pclk);
			i++;
		end while (pready !== 1'b1 && i < 50);
		if (pready !== 1'b1) begin
			errors++;
			end_of_test;
		end
		rdata = prdata;
		slv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		check(rdata, exp);
	endtask
	task automatic pins(input logic [7:0] v);
		u_far.drive(v);
		repeat (4) @(posedge pclk);
	endtask

	// 25 mhz clock
	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end

	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		errors = 0;
		cmp_count = 0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		// reset values of every register
		for (int i = 0; i < 7; i++) rd(8'(4 * i), 32'h0000_0000);
		check(slv, 1'b0);
		// unmapped address refused
		rd(8'h1c, 32'h0000_0000);
		check(slv, 1'b1);
		// lines 0..3 in low, fall, rise, both
		wr(ISF_OFF_SENSE, 32'h0000_00e4);
		wr(ISF_OFF_ENABLE, 32'h0000_000f);
		pins(8'hf0);
		rd(ISF_OFF_STATUS, 32'h0000_000b); // low fall both
		check(ext_request, 8'h0b); // enabled request
		check(irq, 1'b1); // level output
		wr(ISF_OFF_ENABLE, 32'h0000_0001);
		check(ext_request, 8'h01); // masked lines
		pins(8'hff);
		rd(ISF_OFF_STATUS, 32'h0000_000f); // rising edge
		wr(ISF_OFF_STATUS, 32'hffff_ffff);
		rd(ISF_OFF_STATUS, 32'h0000_000f); // ones ignored
		wr(ISF_OFF_STATUS, 32'h0000_000e);
		rd(ISF_OFF_STATUS, 32'h0000_000e); // zero clears
		u_far.handle(1);
		rd(ISF_OFF_STATUS, 32'h0000_000c); // falling edge clear
		u_far.handle(3);
		rd(ISF_OFF_STATUS, 32'h0000_0004); // both edge clear
		// low mode: handling while pin low keeps flag
		pins(8'hfe);
		u_far.handle(0);
		rd(ISF_OFF_STATUS, 32'h0000_0005); // pin low
		pins(8'hff);
		u_far.handle(0);
		rd(ISF_OFF_STATUS, 32'h0000_0004); // pin high clears
		// transfer controller fitted: no automatic clear
		wr(ISF_OFF_CONFIG, 32'h0000_0001);
		u_far.handle(2);
		rd(ISF_OFF_STATUS, 32'h0000_0004); // flag kept
		wr(ISF_OFF_STATUS, 32'h0000_0000);
		rd(ISF_OFF_STATUS, 32'h0000_0000); // software clear
		check(irq, 1'b0); // no pending line
		// key-in and wake-up events, only wake-up unmasked
		wr(ISF_OFF_EVT_MASK, 32'h0000_0002);
		u_far.blip(1'b0, 5);
		repeat (4) @(posedge pclk);
		rd(ISF_OFF_EVT_STATUS, 32'h0000_0001); // key-in event
		check(irq, 1'b0); // masked key event
		u_far.blip(1'b1, 2);
		repeat (4) @(posedge pclk);
		rd(ISF_OFF_EVT_STATUS, 32'h0000_0003); // wake-up event
		check(irq, 1'b1); // unmasked wake event
		wr(ISF_OFF_EVT_STATUS, 32'h0000_0003);
		rd(ISF_OFF_EVT_STATUS, 32'h0000_0000); // event cleared
		check(irq, 1'b0); // no pending event
		// ten level bits only, nmi and break have none
		wr(ISF_OFF_LEVEL, 32'hffff_ffff);
		rd(ISF_OFF_LEVEL, 32'h0000_03ff); // level bits
		check(source_level, 10'h3ff); // level output
		end_of_test;
	end
endmodule
